// >>> pkg/gpp_pkg.sv
// Purpose: constants for the general purpose port bit logic
// Assumes: eight bits per port, configuration held per bit in three control registers
// Notes:   register offsets are byte addresses on the APB slave
package gpp_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_DATA        = 8'h00;
    localparam logic [7:0] ADDR_CFG_ZERO    = 8'h04;
    localparam logic [7:0] ADDR_CFG_ONE     = 8'h08;
    localparam logic [7:0] ADDR_CFG_LEVEL   = 8'h0C;
    localparam logic [7:0] ADDR_AF_ENABLE   = 8'h10;
    localparam logic [7:0] ADDR_STATUS      = 8'h14;
    // reset values
    localparam logic [7:0] RST_DATA         = 8'hFF;
    localparam logic [7:0] RST_CFG          = 8'h00;
    localparam logic [7:0] RST_AF_ENABLE    = 8'h00;
    // status field positions
    localparam int         STAT_WAIT_POS    = 0;
    localparam int         STAT_HALT_POS    = 1;
    // decoded bit modes
    typedef enum logic [1:0] {
        MODE_BID,
        MODE_OUT,
        MODE_IN,
        MODE_AF
    } gpp_mode_type;
endpackage

// >>> core/gpp_bit.sv
// Purpose: one port bit: mode decode, input latch, slave latch and pin driver
// Assumes: start and end strobes are one-cycle pulses from the core
// Notes:   pin output enable is high while the bit drives the pin
module gpp_bit
    import gpp_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // configuration
    input  wire logic cfg_zero_i,
    input  wire logic cfg_one_i,
    input  wire logic level_i,
    input  wire logic pullup_ok_i,
    input  wire logic adc_bit_i,
    // timing strobes
    input  wire logic start_i,
    input  wire logic end_i,
    input  wire logic wr_i,
    input  wire logic wr_data_i,
    // pin and peripherals
    input  wire logic pin_sync_i,
    input  wire logic alt_output_mode_i,
    input  wire logic af_present_i,
    // results
    output logic      master_o,
    output logic      in_latch_o,
    output logic      pin_o,
    output logic      pin_oe_o,
    output logic      weak_pu_o
);
    logic         master;
    logic         slave;
    logic         in_latch;
    gpp_mode_type mode;
    logic         next_pin;
    logic         next_oe;
    logic         next_pu;

    // decode of the two mode control bits
    always_comb begin
        unique case ({cfg_one_i, cfg_zero_i})
            2'b00: mode = MODE_BID;
            2'b01: mode = MODE_IN;
            2'b10: mode = MODE_OUT;
            2'b11: mode = MODE_AF;
        endcase
    end

    // master latch loads on any write to the data register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            master <= 1'b1;
        end else if (wr_i) begin
            master <= wr_data_i;
        end
    end

    // slave latch copies master at instruction end, in every mode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slave <= 1'b1;
        end else if (end_i) begin
            slave <= master;
        end
    end

    // input latch: pin at start, or master at end in output mode
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_latch <= 1'b1;
        end else if (mode == MODE_OUT && end_i) begin
            in_latch <= master;
        end else if (mode != MODE_OUT && start_i) begin
            in_latch <= pin_sync_i;
        end
    end

    // pin driver per mode and output type
    always_comb begin
        next_pin = 1'b0;
        next_oe  = 1'b0;
        next_pu  = 1'b0;
        unique case (mode)
            MODE_IN: begin
                next_oe = 1'b0;
            end
            MODE_OUT: begin
                next_pin = slave;
                next_oe  = level_i ? !slave : 1'b1;
            end
            MODE_BID: begin
                next_pin = slave;
                next_oe  = !slave;
                next_pu  = !level_i && pullup_ok_i && slave;
            end
            MODE_AF: begin
                if (level_i && adc_bit_i) begin
                    next_pin = 1'b1;
                    next_oe  = 1'b0;
                end else if (!af_present_i) begin
                    next_pin = 1'b1;
                    next_oe  = !level_i;
                end else begin
                    next_pin = alt_output_mode_i;
                    next_oe  = level_i ? !alt_output_mode_i : 1'b1;
                end
            end
        endcase
    end

    // registered pin outputs
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_o     <= 1'b0;
            pin_oe_o  <= 1'b0;
            weak_pu_o <= 1'b0;
        end else begin
            pin_o     <= next_pin;
            pin_oe_o  <= next_oe;
            weak_pu_o <= next_pu;
        end
    end

    assign master_o   = master;
    assign in_latch_o = in_latch;
endmodule

// >>> core/gpp_port.sv
// Purpose: eight-bit general purpose port with APB register access
// Assumes: core gives instruction start and end strobes on the same clock
// Notes:   the pin level seen by peripherals is the synchronised pad level
//
// Design decisions made here: register access over APB and the placing of the registers.
module gpp_port
    import gpp_pkg::*;
#(
    parameter int WIDTH    = 8,
    parameter int AF_COUNT = 2
)
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    // apb slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [7:0]          paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // core timing and power state
    input  wire logic                instr_start_i,
    input  wire logic                instr_end_i,
    input  wire logic                wait_state_i,
    input  wire logic                halt_state_i,
    // hardware options per bit
    input  wire logic [WIDTH-1:0]    pullup_ok_i,
    input  wire logic [WIDTH-1:0]    adc_bit_i,
    // peripheral alternate outputs, one word per peripheral
    input  wire logic [AF_COUNT*WIDTH-1:0] alt_output_mode_i,
    // pins
    input  wire logic [WIDTH-1:0]    pin_i,
    output logic      [WIDTH-1:0]    pin_o,
    output logic      [WIDTH-1:0]    pin_oe_o,
    output logic      [WIDTH-1:0]    weak_pu_o,
    // alternate inputs to peripherals
    output logic      [WIDTH-1:0]    alt_input_mode_o
);
    initial begin
        // reset constants are eight bits wide and every register is one bus word
        if (WIDTH < 1 || WIDTH > 8 || AF_COUNT < 1 || AF_COUNT * WIDTH > 32) begin
            $error("gpp_port: unsupported WIDTH or AF_COUNT");
        end
    end

    logic             rst_meta;
    logic             rst_sync;
    logic [WIDTH-1:0] pin_meta;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] cfg_zero;
    logic [WIDTH-1:0] cfg_one;
    logic [WIDTH-1:0] cfg_level;
    logic [AF_COUNT*WIDTH-1:0] af_enable;
    logic [WIDTH-1:0] master;
    logic [WIDTH-1:0] in_latch;
    logic [WIDTH-1:0] af_and;
    logic [WIDTH-1:0] af_present;
    logic             wr_data;
    logic [31:0]      next_rdata;
    logic             access;
    logic             mapped;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // pin synchroniser
    always_ff @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_i;
            pin_sync <= pin_meta;
        end
    end

    // address decode helper
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    assign access  = psel_i && penable_i;
    assign wr_data = access && pwrite_i && is_addr(paddr_i, ADDR_DATA);
    assign mapped  = is_addr(paddr_i, ADDR_DATA) || is_addr(paddr_i, ADDR_CFG_ZERO)
                  || is_addr(paddr_i, ADDR_CFG_ONE) || is_addr(paddr_i, ADDR_CFG_LEVEL)
                  || is_addr(paddr_i, ADDR_AF_ENABLE) || is_addr(paddr_i, ADDR_STATUS);

    // configuration registers; all zero gives bidirectional weak pull-up
    always_ff @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            cfg_zero  <= RST_CFG[WIDTH-1:0];
            cfg_one   <= RST_CFG[WIDTH-1:0];
            cfg_level <= RST_CFG[WIDTH-1:0];
        end else if (access && pwrite_i) begin
            if (is_addr(paddr_i, ADDR_CFG_ZERO)) begin
                cfg_zero <= pwdata_i[WIDTH-1:0];
            end
            if (is_addr(paddr_i, ADDR_CFG_ONE)) begin
                cfg_one <= pwdata_i[WIDTH-1:0];
            end
            if (is_addr(paddr_i, ADDR_CFG_LEVEL)) begin
                cfg_level <= pwdata_i[WIDTH-1:0];
            end
        end
    end

    // alternate output enables, one word per peripheral
    always_ff @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            af_enable <= '0;
        end else if (access && pwrite_i && is_addr(paddr_i, ADDR_AF_ENABLE)) begin
            af_enable <= pwdata_i[AF_COUNT*WIDTH-1:0];
        end
    end

    // and of the enabled alternate outputs; disabled ones read as one
    always_comb begin
        af_and     = '1;
        af_present = '0;
        for (int k = 0; k < AF_COUNT; k++) begin
            af_and     = af_and & (alt_output_mode_i[k*WIDTH +: WIDTH]
                       | ~af_enable[k*WIDTH +: WIDTH]);
            af_present = af_present | af_enable[k*WIDTH +: WIDTH];
        end
    end

    // per-bit latches and driver; slave and input latches only move on strobes, so wait
    // and halt, which stop the strobes, leave every latch-driven pin as it was
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            gpp_bit u_bit (
                .clk_i        (clk_i),
                .rst_b_i      (rst_sync),
                .cfg_zero_i   (cfg_zero[g]),
                .cfg_one_i    (cfg_one[g]),
                .level_i      (cfg_level[g]),
                .pullup_ok_i  (pullup_ok_i[g]),
                .adc_bit_i    (adc_bit_i[g]),
                .start_i      (instr_start_i),
                .end_i        (instr_end_i),
                .wr_i         (wr_data),
                .wr_data_i    (pwdata_i[g]),
                .pin_sync_i   (pin_sync[g]),
                .alt_output_mode_i     (af_and[g]),
                .af_present_i (af_present[g]),
                .master_o     (master[g]),
                .in_latch_o   (in_latch[g]),
                .pin_o        (pin_o[g]),
                .pin_oe_o     (pin_oe_o[g]),
                .weak_pu_o    (weak_pu_o[g])
            );
        end
    endgenerate

    // alternate inputs see the pad, including the port's own drive
    always_ff @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            alt_input_mode_o <= '0;
        end else begin
            alt_input_mode_o <= pin_sync;
        end
    end

    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (is_addr(paddr_i, ADDR_DATA)) begin
            next_rdata[WIDTH-1:0] = in_latch;
        end else if (is_addr(paddr_i, ADDR_CFG_ZERO)) begin
            next_rdata[WIDTH-1:0] = cfg_zero;
        end else if (is_addr(paddr_i, ADDR_CFG_ONE)) begin
            next_rdata[WIDTH-1:0] = cfg_one;
        end else if (is_addr(paddr_i, ADDR_CFG_LEVEL)) begin
            next_rdata[WIDTH-1:0] = cfg_level;
        end else if (is_addr(paddr_i, ADDR_AF_ENABLE)) begin
            next_rdata[AF_COUNT*WIDTH-1:0] = af_enable;
        end else if (is_addr(paddr_i, ADDR_STATUS)) begin
            next_rdata[STAT_WAIT_POS] = wait_state_i;
            next_rdata[STAT_HALT_POS] = halt_state_i;
        end
    end

    // apb answer: ready in the first cycle of the access phase
    always_ff @(posedge clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !mapped;
            prdata_o  <= next_rdata;
        end
    end
endmodule

// >>> tb/gpp_port_properties.sv
// Purpose: bus and pin checks on the port block
// Assumes: zero wait state slave with registered answer
// Notes:   bound to every instance of the port
module gpp_port_properties
    import gpp_pkg::*;
#(
    parameter int WIDTH    = 8,
    parameter int AF_COUNT = 2
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // apb
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [7:0]       paddr_i,
    input  wire logic [31:0]      prdata_o,
    input  wire logic             pready_o,
    input  wire logic             pslverr_o,
    // pins
    input  wire logic [WIDTH-1:0] pullup_ok_i,
    input  wire logic [WIDTH-1:0] pin_oe_o,
    input  wire logic [WIDTH-1:0] weak_pu_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mapped;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // address decode of the six registers
    assign mapped = paddr_i inside {ADDR_DATA, ADDR_CFG_ZERO, ADDR_CFG_ONE,
                                    ADDR_CFG_LEVEL, ADDR_AF_ENABLE, ADDR_STATUS};
    // apb phases
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_answer;
        psel_i && penable_i && pready_o;
    endsequence
    a_ready_timing: assert property (s_setup |=> s_answer)
        else $error("no answer in first access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_ready_cause: assert property (pready_o |-> $past(psel_i && !penable_i))
        else $error("ready without setup");
    a_err_unmapped: assert property (pready_o && !mapped |-> pslverr_o)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready_o && mapped |-> !pslverr_o)
        else $error("mapped access refused");
    a_err_data: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("refused read returned data");
    a_reset_float: assert property (disable iff (1'b0) !rst_b_i |-> pin_oe_o == '0)
        else $error("pin driven in reset");
    a_pull_allowed: assert property ((weak_pu_o & ~$past(pullup_ok_i)) == '0)
        else $error("pull-up on disabled bit");
    a_pull_no_drive: assert property ((weak_pu_o & pin_oe_o) == '0)
        else $error("pull-up while driving");
endmodule

bind gpp_port gpp_port_properties #(
    .WIDTH    (WIDTH),
    .AF_COUNT (AF_COUNT)
) chk_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pullup_ok_i(pullup_ok_i), .pin_oe_o(pin_oe_o),
    .weak_pu_o(weak_pu_o)
);

// >>> tb/gpp_pin_model.sv
// Purpose: pad model resolving design drive, outside drivers and pull-up
// Assumes: design drive wins over outside drivers
// Notes:   an undriven pad without pull-up wanders every cycle
module gpp_pin_model
#(
    parameter int WIDTH = 8
)
(
    // clock
    input  wire logic             clk_i,
    // design drive
    input  wire logic [WIDTH-1:0] drv_i,
    input  wire logic [WIDTH-1:0] drv_en_i,
    input  wire logic [WIDTH-1:0] pull_i,
    // outside drivers
    input  wire logic [WIDTH-1:0] ext_en_i,
    input  wire logic [WIDTH-1:0] ext_val_i,
    // resolved pad level
    output logic      [WIDTH-1:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WIDTH-1:0] drift = '0;
    // floating level changes every cycle
    always @(posedge clk_i) drift <= ~drift;
    // driver, then outside, then weak pull-up, else float
    assign pin_i = (drv_en_i & drv_i) | (~drv_en_i & ext_en_i & ext_val_i)
                 | (~drv_en_i & ~ext_en_i & pull_i)
                 | (~drv_en_i & ~ext_en_i & ~pull_i & drift);
endmodule

// >>> tb/gpp_port_test.sv
// Purpose: self-checking bench for the eight-bit port block
// Assumes: zero wait state slave, outputs settle within a few cycles
// Notes:   pads come from the pin model, peripherals from the bench
module gpp_port_test
    import gpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_b_i, psel, penable, pwrite, st, en, wt, ht, pready, perr, qerr;
    logic [7:0]  paddr, pu_ok, adc, pin_i, pin_o, oe, wpu, alt_input_mode, x_en, x_val;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] alt_output_mode;
    int          fail_count, checked;
    // design and pads
    gpp_port dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(perr), .instr_start_i(st), .instr_end_i(en),
        .wait_state_i(wt), .halt_state_i(ht), .pullup_ok_i(pu_ok), .adc_bit_i(adc),
        .alt_output_mode_i(alt_output_mode), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(oe), .weak_pu_o(wpu),
        .alt_input_mode_o(alt_input_mode));
    gpp_pin_model pad_u (.clk_i(clk_i), .drv_i(pin_o), .drv_en_i(oe), .pull_i(wpu),
        .ext_en_i(x_en), .ext_val_i(x_val), .pin_i(pin_i));
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer, answer taken at the edge that sees pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        // pready is read at the rising edge, before the design updates it
        @(posedge clk_i);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20) fail_count++;
        q = prdata;
        qerr = perr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task strobe(input logic s, input logic e);
        @(posedge clk_i);
        st <= s; en <= e;
        @(posedge clk_i);
        st <= 1'b0; en <= 1'b0;
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task mode(input logic [7:0] one, input logic [7:0] zero, input logic [7:0] lvl);
        apb(1'b1, ADDR_CFG_ONE, {24'h0, one});
        apb(1'b1, ADDR_CFG_ZERO, {24'h0, zero});
        apb(1'b1, ADDR_CFG_LEVEL, {24'h0, lvl});
    endtask
    task t_reset;
        apb(1'b0, ADDR_DATA, 32'h0); check("data", q, {24'h0, RST_DATA});
        for (int i = 1; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0); check("cfg", q, {24'h0, RST_CFG});
        end
        check("pull", {24'h0, wpu}, 32'hFF);
        check("oe", {24'h0, oe}, 32'h0);
        apb(1'b0, 8'h18, 32'h0); check("err", {31'h0, qerr}, 32'h1);
        check("err data", q, 32'h0);
        wt <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0); check("wait", q, 32'h1);
        wt <= 1'b0; ht <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0); check("halt", q, 32'h2);
        ht <= 1'b0;
    endtask
    task t_output;
        mode(8'hFF, 8'h00, 8'h00);
        apb(1'b1, ADDR_DATA, 32'h5A);
        settle(2); check("early", {24'h0, pin_o}, 32'hFF);
        strobe(1'b0, 1'b1); settle(2);
        check("pp pin", {24'h0, pin_o}, 32'h5A);
        check("pp oe", {24'h0, oe}, 32'hFF);
        apb(1'b0, ADDR_DATA, 32'h0); check("readback", q, 32'h5A);
        apb(1'b1, ADDR_CFG_LEVEL, 32'hFF); apb(1'b1, ADDR_DATA, 32'hA5);
        strobe(1'b0, 1'b1); settle(2);
        check("od oe", {24'h0, oe}, 32'h5A);
    endtask
    task t_input;
        mode(8'h00, 8'hFF, 8'h00);
        x_en <= 8'hFF; x_val <= 8'h3C;
        settle(4); check("in oe", {24'h0, oe}, 32'h0);
        check("alt_input_mode", {24'h0, alt_input_mode}, 32'h3C);
        strobe(1'b1, 1'b0); settle(2);
        apb(1'b0, ADDR_DATA, 32'h0); check("in read", q, 32'h3C);
        apb(1'b1, ADDR_DATA, 32'h77); strobe(1'b0, 1'b1);
        x_en <= 8'h00; mode(8'hFF, 8'h00, 8'h00); settle(2);
        check("slave", {24'h0, pin_o}, 32'h77);
    endtask
    task t_bid;
        mode(8'h00, 8'h00, 8'h00);
        apb(1'b1, ADDR_DATA, 32'h0F); strobe(1'b0, 1'b1);
        x_en <= 8'h0C; x_val <= 8'h00; settle(4);
        check("bid pull", {24'h0, wpu}, 32'h0F);
        check("bid oe", {24'h0, oe}, 32'hF0);
        strobe(1'b1, 1'b0); settle(2);
        apb(1'b0, ADDR_DATA, 32'h0); check("bid read", q, 32'h03);
        apb(1'b1, ADDR_DATA, q | 32'h80); strobe(1'b0, 1'b1); settle(4);
        strobe(1'b1, 1'b0); settle(2);
        apb(1'b0, ADDR_DATA, 32'h0); check("rmw", q, 32'h83);
        check("rmw oe", {24'h0, oe}, 32'h7C);
        x_en <= 8'h00;
    endtask
    task t_alt;
        mode(8'hFF, 8'hFF, 8'h00); settle(3);
        check("none pp", {24'h0, pin_o & oe}, 32'hFF);
        apb(1'b1, ADDR_CFG_LEVEL, 32'hFF); settle(3);
        check("none od", {24'h0, oe}, 32'h0);
        alt_output_mode <= 16'hF03C; apb(1'b1, ADDR_CFG_LEVEL, 32'h0);
        apb(1'b1, ADDR_AF_ENABLE, 32'h00FF); settle(3);
        check("one", {24'h0, pin_o}, 32'h3C);
        apb(1'b1, ADDR_AF_ENABLE, 32'hFFFF); settle(5);
        check("and", {24'h0, pin_o}, 32'h30);
        check("loop", {24'h0, alt_input_mode}, 32'h30);
        strobe(1'b1, 1'b0); settle(2);
        apb(1'b0, ADDR_DATA, 32'h0); check("af read", q, 32'h30);
        adc <= 8'h01; apb(1'b1, ADDR_CFG_LEVEL, 32'hFF); settle(3);
        check("adc", {24'h0, oe}, 32'hCE);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // watchdog well beyond the few hundred cycles of the run
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        close_out;
    end
    // main sequence
    initial begin
        rst_b_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
        pwdata = 32'h0; st = 1'b0; en = 1'b0; wt = 1'b0; ht = 1'b0; pu_ok = 8'hFF;
        adc = 8'h0; alt_output_mode = 16'h0; x_en = 8'h0; x_val = 8'h0; qerr = 1'b0; q = 32'h0;
        fail_count = 0; checked = 0;
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        settle(4);
        t_reset; t_output; t_input; t_bid; t_alt;
        close_out;
    end
endmodule
